/* design/orfw_osc_ready.sv */
`timescale 1ns/10ps
module orfw_osc_ready #(
   parameter int LONG_CNT  = orfw_pkg::CRYSTAL_CNT,
   parameter int SHORT_CNT = orfw_pkg::FAST_RC_CNT
) (
   input  wire logic mclk,
   input  wire logic rst,
   input  wire logic run,
   input  wire logic tick,
   input  wire logic long_mode,
   output logic      ready_q
);
   // ==========================================================================
   // Checks
   // ==========================================================================
   if (LONG_CNT < 1 || SHORT_CNT < 1 || LONG_CNT >= (1 << orfw_pkg::CNT_W) ||
       SHORT_CNT >= (1 << orfw_pkg::CNT_W)) begin : g_chk
      $error("orfw_osc_ready: counts out of range");
   end

   logic [orfw_pkg::CNT_W-1:0] cnt_q;
   logic [orfw_pkg::CNT_W-1:0] last;

   // The last tick index; a first partial cycle makes the wait one cycle short.
   assign last = long_mode ? orfw_pkg::CNT_W'(LONG_CNT - 1) : orfw_pkg::CNT_W'(SHORT_CNT - 1);

   // ==========================================================================
   // Counter
   // ==========================================================================
   // A stopped oscillator loses its stability, so the count restarts.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         cnt_q <= '0;
      end else if (!run) begin
         cnt_q <= '0;
      end else if (tick && !ready_q) begin
         cnt_q <= cnt_q + 1'b1;
      end
   end

   // Ready rises on the tick that completes the count and falls when stopped.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ready_q <= 1'b0;
      end else if (!run) begin
         ready_q <= 1'b0;
      end else if (tick && cnt_q >= last) begin
         ready_q <= 1'b1;
      end
   end
endmodule

/* design/orfw_pkg.sv */
package orfw_pkg;
   // ==========================================================================
   // Register map
   // ==========================================================================
   localparam logic [7:0]  ADDR_MODE_CTRL = 8'h00;
   localparam logic [7:0]  ADDR_STATUS    = 8'h04;

   // Mode control field positions.
   localparam int          BIT_QWE        = 4;
   localparam int          BIT_LOW_RDY    = 3;
   localparam int          BIT_HIGH_RDY   = 2;
   localparam int          BIT_LIGHT      = 1;
   localparam logic [7:0]  MODE_CTRL_RST  = 8'h03;
   localparam logic [7:0]  MODE_CTRL_WMSK = 8'hf3;

   // ==========================================================================
   // Stabilisation counts, in oscillator cycles
   // ==========================================================================
   localparam int          CNT_W          = 11;
   localparam int          CRYSTAL_CNT    = 1024;
   localparam int          FAST_RC_CNT    = 16;
   localparam int          SLOW_RC_CNT    = 2;
   localparam int          SUB_WAKE_CNT   = 2;

   // Power mode codes shown in the status register.
   localparam logic [2:0]  PM_RUN         = 3'h0;
   localparam logic [2:0]  PM_DEEP        = 3'h1;
   localparam logic [2:0]  PM_SLEEP_SUB   = 3'h2;
   localparam logic [2:0]  PM_DOZE_OFF    = 3'h3;
   localparam logic [2:0]  PM_DOZE_RUN    = 3'h4;
   localparam logic [2:0]  PM_WAKING      = 3'h5;

   // ==========================================================================
   // Types
   // ==========================================================================
   typedef enum logic [2:0] {
      OSC_FAST_CRYSTAL,
      OSC_EXTERNAL_RC,
      OSC_FAST_INTERNAL_RC,
      OSC_SLOW_INTERNAL_RC,
      OSC_SLOW_CRYSTAL
   } orfw_osc_e;

   typedef struct packed {
      logic [7:0]  paddr;
      logic        pwrite;
      logic [31:0] pwdata;
   } orfw_apb_req_s;

   typedef struct packed {
      logic        stop_instruction;
      logic        wake_event;
      logic        wdt_on;
      logic        lvd_on;
      logic        keep_sysclk_in_doze;
   } orfw_sys_s;
endpackage

/* design/orfw_top.sv */
// The register offsets and register access over APB were left to the implementer.
`timescale 1ns/10ps
// How it works
// - The low-speed ready flag is low in deep sleep and rises 1024 ticks after wake for the slow crystal, 1 to 2 for the slow RC.
// - The high-speed ready flag is zero after power-on, rises once the oscillator is stable and software cannot write it.
// - The high-speed ready flag is low in sleep and clock-off doze and rises 1024 ticks after wake for the fast crystal, 15 to 16 for an RC.
// - A stop instruction enters doze when the light-sleep bit is one and sleep when it is zero.
// - Doze keeps the system clock running for peripherals when keep_sysclk_in_doze is high, otherwise stops CPU and clock.
// - Fast wake-up is offered only from sleep with sub clock or clock-off doze, with the sub clock as temporary system clock.
// - Waking from deep sleep ignores quick_wake_enable since the sub clock is stopped.
// - The quick_wake_enable bit of the mode register turns fast wake-up on or off.
// - With the fast crystal and fast wake-up, the CPU runs on the sub clock after 1 to 2 sub ticks until the crystal is ready, then switches.
// - RC system oscillators wake in 15 to 16 fast RC ticks or 1 to 2 slow RC ticks.
// - quick_wake_enable has no effect when the system oscillator is an RC type.
// - Sleep with the light bit clear goes to deep sleep when watchdog and voltage detector are off, else to sleep with sub clock.
module orfw_top (
   input  wire logic                  mclk,
   input  wire logic                  rst,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire orfw_pkg::orfw_apb_req_s apb_req,
   output logic [31:0]                prdata_q,
   output logic                       pready_q,
   output logic                       pslverr_q,
   input  wire orfw_pkg::orfw_sys_s   sys_in,
   input  wire orfw_pkg::orfw_osc_e   sys_osc,
   input  wire logic                  low_is_crystal,
   input  wire logic                  high_tick,
   input  wire logic                  low_tick,
   output logic                       low_osc_ready_q,
   output logic                       high_osc_ready_q,
   output logic                       cpu_run_q,
   output logic                       sysclk_run_q,
   output logic                       sysclk_from_sub_q,
   output logic                       subclk_run_q,
   output logic [2:0]                 power_mode_q
);
   typedef enum logic [2:0] {
      ST_RUN, ST_DEEP, ST_SLEEP_SUB, ST_DOZE_OFF, ST_DOZE_RUN,
      ST_WAKE_WAIT, ST_WAKE_SUB, ST_WAKE_FAST
   } orfw_state_e;

   orfw_state_e state_q;
   orfw_state_e state_d;
   logic [7:0]  ctrl_q;
   logic        sub_cnt_q;
   logic        high_run;
   logic        low_run;
   logic        low_sys;
   logic        sel_ready;
   logic        fast_ok;
   logic        setup;
   logic        wr_access;
   logic        mapped;

   // ==========================================================================
   // Helpers
   // ==========================================================================
   // Mode code seen by software and on the power_mode output.
   function automatic logic [2:0] mode_of(input orfw_state_e s);
      case (s)
         ST_RUN:       mode_of = orfw_pkg::PM_RUN;
         ST_DEEP:      mode_of = orfw_pkg::PM_DEEP;
         ST_SLEEP_SUB: mode_of = orfw_pkg::PM_SLEEP_SUB;
         ST_DOZE_OFF:  mode_of = orfw_pkg::PM_DOZE_OFF;
         ST_DOZE_RUN:  mode_of = orfw_pkg::PM_DOZE_RUN;
         default:      mode_of = orfw_pkg::PM_WAKING;
      endcase
   endfunction

   // A halted state with the system clock stopped whose sub clock keeps running.
   function automatic logic sub_alive(input orfw_state_e s);
      sub_alive = (s == ST_SLEEP_SUB) || (s == ST_DOZE_OFF);
   endfunction

   // ==========================================================================
   // Oscillator stability
   // ==========================================================================
   // The high-speed source stops in deep sleep, sleep with sub clock and clock-off doze.
   assign high_run = !(state_q == ST_DEEP || sub_alive(state_q));
   // The low-speed source only stops in deep sleep.
   assign low_run  = (state_q != ST_DEEP);
   assign low_sys  = (sys_osc == orfw_pkg::OSC_SLOW_INTERNAL_RC) ||
                     (sys_osc == orfw_pkg::OSC_SLOW_CRYSTAL);

   orfw_osc_ready #(
      .LONG_CNT  (orfw_pkg::CRYSTAL_CNT),
      .SHORT_CNT (orfw_pkg::FAST_RC_CNT)
   ) u_high_rdy (
      .mclk      (mclk),
      .rst       (rst),
      .run       (high_run),
      .tick      (high_tick),
      .long_mode (sys_osc == orfw_pkg::OSC_FAST_CRYSTAL),
      .ready_q   (high_osc_ready_q)
   );

   orfw_osc_ready #(
      .LONG_CNT  (orfw_pkg::CRYSTAL_CNT),
      .SHORT_CNT (orfw_pkg::SLOW_RC_CNT)
   ) u_low_rdy (
      .mclk      (mclk),
      .rst       (rst),
      .run       (low_run),
      .tick      (low_tick),
      .long_mode (low_is_crystal),
      .ready_q   (low_osc_ready_q)
   );

   // Readiness of whichever oscillator is the system clock.
   assign sel_ready = low_sys ? low_osc_ready_q : high_osc_ready_q;

   // Only the fast crystal benefits; deep sleep has no sub clock to lend.
   assign fast_ok = sub_alive(state_q) && ctrl_q[orfw_pkg::BIT_QWE] &&
                    (sys_osc == orfw_pkg::OSC_FAST_CRYSTAL);

   // ==========================================================================
   // Power state machine
   // ==========================================================================
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_RUN: begin
            if (sys_in.stop_instruction) begin
               if (ctrl_q[orfw_pkg::BIT_LIGHT]) begin
                  state_d = sys_in.keep_sysclk_in_doze ? ST_DOZE_RUN : ST_DOZE_OFF;
               end else begin
                  state_d = (sys_in.wdt_on || sys_in.lvd_on) ? ST_SLEEP_SUB : ST_DEEP;
               end
            end
         end
         ST_DEEP, ST_SLEEP_SUB, ST_DOZE_OFF, ST_DOZE_RUN: begin
            if (sys_in.wake_event) begin
               state_d = fast_ok ? ST_WAKE_SUB : ST_WAKE_WAIT;
            end
         end
         ST_WAKE_SUB: begin
            if (low_tick && sub_cnt_q) begin
               state_d = ST_WAKE_FAST;
            end
         end
         ST_WAKE_FAST: begin
            if (high_osc_ready_q) begin
               state_d = ST_RUN;
            end
         end
         ST_WAKE_WAIT: begin
            if (sel_ready) begin
               state_d = ST_RUN;
            end
         end
         default: state_d = ST_RUN;
      endcase
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state_q <= ST_RUN;
      end else begin
         state_q <= state_d;
      end
   end

   // Counts sub clock ticks while waiting for the temporary clock.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         sub_cnt_q <= 1'b0;
      end else if (state_q != ST_WAKE_SUB) begin
         sub_cnt_q <= 1'b0;
      end else if (low_tick) begin
         sub_cnt_q <= 1'b1;
      end
   end

   // Clock controls are registered from the next state so they track state_q.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         cpu_run_q         <= 1'b1;
         sysclk_run_q      <= 1'b1;
         sysclk_from_sub_q <= 1'b0;
         subclk_run_q      <= 1'b1;
         power_mode_q      <= orfw_pkg::PM_RUN;
      end else begin
         cpu_run_q         <= (state_d == ST_RUN) || (state_d == ST_WAKE_FAST);
         sysclk_run_q      <= (state_d == ST_RUN) || (state_d == ST_DOZE_RUN) ||
                              (state_d == ST_WAKE_FAST);
         sysclk_from_sub_q <= (state_d == ST_WAKE_FAST);
         subclk_run_q      <= (state_d != ST_DEEP);
         power_mode_q      <= mode_of(state_d);
      end
   end

   // ==========================================================================
   // APB slave
   // ==========================================================================
   // Zero wait states: every access phase is answered at once.
   assign setup     = psel && !penable;
   assign mapped    = (apb_req.paddr == orfw_pkg::ADDR_MODE_CTRL) ||
                      (apb_req.paddr == orfw_pkg::ADDR_STATUS);
   assign wr_access = psel && penable && pready_q && apb_req.pwrite;

   // The ready flags are live bits; writes to them are dropped.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ctrl_q <= orfw_pkg::MODE_CTRL_RST;
      end else if (wr_access && apb_req.paddr == orfw_pkg::ADDR_MODE_CTRL) begin
         ctrl_q <= apb_req.pwdata[7:0] & orfw_pkg::MODE_CTRL_WMSK;
      end
   end

   // Read data is captured in the setup cycle and stands through the access.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         prdata_q  <= '0;
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         pready_q  <= setup;
         pslverr_q <= setup && !mapped;
         if (setup && !apb_req.pwrite) begin
            if (apb_req.paddr == orfw_pkg::ADDR_MODE_CTRL) begin
               prdata_q <= {24'h000000, ctrl_q[7:4], low_osc_ready_q,
                            high_osc_ready_q, ctrl_q[1:0]};
            end else if (apb_req.paddr == orfw_pkg::ADDR_STATUS) begin
               prdata_q <= {25'h0000000, sysclk_from_sub_q, sysclk_run_q,
                            cpu_run_q, 1'b0, power_mode_q};
            end else begin
               prdata_q <= '0;
            end
         end
      end
   end

   // ==========================================================================
   // Assertions
   // ==========================================================================
   sequence s_halted_sub;
      sub_alive(state_q) && sys_in.wake_event;
   endsequence

   sequence s_to_fast;
      state_q == ST_WAKE_FAST && high_osc_ready_q;
   endsequence

   a_deep_low_flag: assert property (@(posedge mclk) disable iff (rst)
      (state_q == ST_DEEP && $past(state_q) == ST_DEEP) |-> !low_osc_ready_q)
      else $error("low ready flag high in deep sleep");

   a_sleep_high_flag: assert property (@(posedge mclk) disable iff (rst)
      (!high_run && $past(high_run) == 1'b0) |-> !high_osc_ready_q)
      else $error("high ready flag high while stopped");

   a_halt_select: assert property (@(posedge mclk) disable iff (rst)
      (state_q == ST_RUN && sys_in.stop_instruction && ctrl_q[orfw_pkg::BIT_LIGHT])
      |=> (state_q == ST_DOZE_RUN || state_q == ST_DOZE_OFF))
      else $error("halt did not enter doze");

   a_doze_clock: assert property (@(posedge mclk) disable iff (rst)
      (state_q == ST_DOZE_RUN) |-> (sysclk_run_q && !cpu_run_q))
      else $error("doze clock state wrong");

   a_fast_source: assert property (@(posedge mclk) disable iff (rst)
      (state_q != ST_WAKE_SUB && !(sub_alive(state_q) && ctrl_q[orfw_pkg::BIT_QWE] &&
       sys_osc == orfw_pkg::OSC_FAST_CRYSTAL)) |=> state_q != ST_WAKE_SUB)
      else $error("fast wake from wrong state");

   a_deep_no_fast: assert property (@(posedge mclk) disable iff (rst)
      (state_q == ST_DEEP && sys_in.wake_event) |=> state_q == ST_WAKE_WAIT)
      else $error("deep sleep used fast wake");

   a_rc_no_fast: assert property (@(posedge mclk) disable iff (rst)
      (s_halted_sub and (sys_osc != orfw_pkg::OSC_FAST_CRYSTAL)) |=> state_q == ST_WAKE_WAIT)
      else $error("fast wake with rc oscillator");

   a_fast_switch: assert property (@(posedge mclk) disable iff (rst)
      s_to_fast |=> (state_q == ST_RUN && !sysclk_from_sub_q && cpu_run_q))
      else $error("no switch to crystal");

   a_sleep_select: assert property (@(posedge mclk) disable iff (rst)
      (state_q == ST_RUN && sys_in.stop_instruction && !ctrl_q[orfw_pkg::BIT_LIGHT] &&
       !sys_in.wdt_on && !sys_in.lvd_on) |=> state_q == ST_DEEP)
      else $error("deep sleep not entered");

   a_cpu_hold: assert property (@(posedge mclk) disable iff (rst)
      (state_q == ST_WAKE_WAIT && !sel_ready) |-> !cpu_run_q ##1 (state_q == ST_WAKE_WAIT))
      else $error("cpu ran before oscillator ready");
endmodule

/* sim/orfw_top_tb.sv */
`timescale 1ns/10ps
module orfw_top_tb;
   // ==========================================================================
   // Signals
   // ==========================================================================
   logic                    mclk;
   logic                    rst;
   logic                    psel;
   logic                    penable;
   orfw_pkg::orfw_apb_req_s apb_req;
   logic [31:0]             prdata_q;
   logic                    pready_q;
   logic                    pslverr_q;
   orfw_pkg::orfw_sys_s     sys_in;
   orfw_pkg::orfw_osc_e     sys_osc;
   logic                    low_is_crystal;
   logic                    high_tick;
   logic                    low_tick;
   logic                    low_osc_ready_q;
   logic                    high_osc_ready_q;
   logic                    cpu_run_q;
   logic                    sysclk_run_q;
   logic                    sysclk_from_sub_q;
   logic                    subclk_run_q;
   logic [2:0]              power_mode_q;
   logic                    tick_on;
   logic [2:0]              tick_cnt_q;
   logic [31:0]             rd;
   logic                    err;
   int                      miscompares;
   int                      checked;
   int                      cycles;

   orfw_top i_dut (
      .mclk              (mclk),
      .rst               (rst),
      .psel              (psel),
      .penable           (penable),
      .apb_req           (apb_req),
      .prdata_q          (prdata_q),
      .pready_q          (pready_q),
      .pslverr_q         (pslverr_q),
      .sys_in            (sys_in),
      .sys_osc           (sys_osc),
      .low_is_crystal    (low_is_crystal),
      .high_tick         (high_tick),
      .low_tick          (low_tick),
      .low_osc_ready_q   (low_osc_ready_q),
      .high_osc_ready_q  (high_osc_ready_q),
      .cpu_run_q         (cpu_run_q),
      .sysclk_run_q      (sysclk_run_q),
      .sysclk_from_sub_q (sysclk_from_sub_q),
      .subclk_run_q      (subclk_run_q),
      .power_mode_q      (power_mode_q)
   );

   // ==========================================================================
   // Clock, oscillator ticks and timeout
   // ==========================================================================
   // Free-running 20 MHz clock.
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   // The fast oscillator ticks every second cycle, the slow one every eighth.
   always @(posedge mclk) begin
      tick_cnt_q <= tick_cnt_q + 3'h1;
      high_tick  <= tick_on & tick_cnt_q[0];
      low_tick   <= tick_on & (tick_cnt_q == 3'h7);
   end

   // A hang in any wait loop is cut short here; the whole run needs about 15k cycles.
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         miscompares++;
         test_done();
      end
   end

   // ==========================================================================
   // Tasks
   // ==========================================================================
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic test_done();
      $display("checked=%0d miscompares=%0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // One APB transfer; the request is held until pready is sampled high.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      psel    <= 1'b1;
      penable <= 1'b0;
      apb_req <= '{paddr: a, pwrite: wr, pwdata: wd};
      @(posedge mclk);
      penable <= 1'b1;
      // Only the bench timeout ends a wait that never sees pready.
      do begin
         @(posedge mclk);
      end while (pready_q !== 1'b1);
      rd = prdata_q;
      err = pslverr_q;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask

   // Halt with the given controls, check the mode, wake and count ticks up to each ready flag.
   task automatic halt(input orfw_pkg::orfw_osc_e osc, input logic slow_crystal_osc, input logic light,
                       input logic wdt, input logic lvd, input logic keep, input logic qwe,
                       input logic [2:0] md, input logic sys, input logic sub, input logic fast,
                       input int hlo, input int hhi, input int llo, input int lhi);
      int   nh;
      int   nl;
      logic hs;
      logic ls;
      logic fs;
      logic early;
      logic slow;
      logic rdy;
      int   late;
      int   nf;
      nh = 0;
      nl = 0;
      late = 0;
      nf = 0;
      rdy = 1'b0;
      slow = (osc == orfw_pkg::OSC_SLOW_INTERNAL_RC) || (osc == orfw_pkg::OSC_SLOW_CRYSTAL);
      hs = 1'b0;
      ls = 1'b0;
      fs = 1'b0;
      early = 1'b0;
      sys_osc <= osc;
      low_is_crystal <= slow_crystal_osc;
      sys_in.wdt_on <= wdt;
      sys_in.lvd_on <= lvd;
      sys_in.keep_sysclk_in_doze <= keep;
      apb(1'b1, orfw_pkg::ADDR_MODE_CTRL, {27'h0, qwe, 2'h0, light, 1'b1});
      sys_in.stop_instruction <= 1'b1;
      @(posedge mclk);
      sys_in.stop_instruction <= 1'b0;
      @(posedge mclk);
      chk({cpu_run_q, sysclk_run_q, subclk_run_q, power_mode_q}, {1'b0, sys, sub, md});
      @(posedge mclk);
      chk({low_osc_ready_q, high_osc_ready_q},
          {md != orfw_pkg::PM_DEEP, md == orfw_pkg::PM_DOZE_RUN});
      apb(1'b0, orfw_pkg::ADDR_STATUS, 32'h0);
      chk(rd[2:0], md);
      sys_in.wake_event <= 1'b1;
      @(posedge mclk);
      sys_in.wake_event <= 1'b0;
      for (int i = 0; i < 12000; i++) begin
         @(posedge mclk);
         hs = hs | high_osc_ready_q;
         ls = ls | low_osc_ready_q;
         nh = nh + int'(!hs && high_tick);
         nl = nl + int'(!ls && low_tick);
         nf = nf + int'(!fs && low_tick);
         fs = fs | sysclk_from_sub_q;
         // The CPU may only run on the sub clock or on a ready system oscillator.
         rdy = slow ? low_osc_ready_q : high_osc_ready_q;
         early = early | (cpu_run_q & ~rdy & ~sysclk_from_sub_q);
         late = late + int'(!cpu_run_q && rdy);
         if (cpu_run_q && power_mode_q == orfw_pkg::PM_RUN && hs && ls) begin
            break;
         end
      end
      chk(32'(hlo <= nh && nh <= hhi), 32'h1);
      chk(32'(llo <= nl && nl <= lhi), 32'h1);
      chk(fs, fast);
      chk(early, 1'b0);
      chk({cpu_run_q, power_mode_q}, {1'b1, orfw_pkg::PM_RUN});
      chk(32'(late <= 1), 32'h1);
      chk(32'(!fast || (nf >= 1 && nf <= 2)), 32'h1);
      chk(sysclk_from_sub_q, 1'b0);
      $display("halt test for mode %0d done", md);
   endtask

   // ==========================================================================
   // Main sequence
   // ==========================================================================
   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      apb_req = '0;
      sys_in = '0;
      sys_osc = orfw_pkg::OSC_FAST_INTERNAL_RC;
      low_is_crystal = 1'b0;
      high_tick = 1'b0;
      low_tick = 1'b0;
      tick_on = 1'b0;
      tick_cnt_q = 3'h0;
      miscompares = 0;
      checked = 0;
      cycles = 0;
      repeat (20) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      // Oscillators stay silent first, so both ready bits must read zero.
      apb(1'b0, orfw_pkg::ADDR_MODE_CTRL, 32'h0);
      chk(rd, {24'h0, orfw_pkg::MODE_CTRL_RST});
      apb(1'b1, orfw_pkg::ADDR_MODE_CTRL, 32'hffff_ffff);
      apb(1'b0, orfw_pkg::ADDR_MODE_CTRL, 32'h0);
      chk(rd, 32'h0000_00f3);
      apb(1'b0, 8'h08, 32'h0);
      chk(err, 1'b1);
      chk(rd, 32'h0);
      apb(1'b0, orfw_pkg::ADDR_STATUS, 32'h0);
      chk(rd, 32'h0000_0030);
      tick_on <= 1'b1;
      repeat (100) @(posedge mclk);
      apb(1'b0, orfw_pkg::ADDR_MODE_CTRL, 32'h0);
      chk(rd, 32'h0000_00ff);
      $display("register test done");
      // RC system oscillator: deep sleep, sleep with sub clock and both dozes.
      halt(orfw_pkg::OSC_FAST_INTERNAL_RC, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1,
           orfw_pkg::PM_DEEP, 1'b0, 1'b0, 1'b0, 15, 16, 1, 2);
      halt(orfw_pkg::OSC_EXTERNAL_RC, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1,
           orfw_pkg::PM_SLEEP_SUB, 1'b0, 1'b1, 1'b0, 15, 16, 0, 0);
      halt(orfw_pkg::OSC_FAST_INTERNAL_RC, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0,
           orfw_pkg::PM_DOZE_OFF, 1'b0, 1'b1, 1'b0, 15, 16, 0, 0);
      halt(orfw_pkg::OSC_FAST_INTERNAL_RC, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0,
           orfw_pkg::PM_DOZE_RUN, 1'b1, 1'b1, 1'b0, 0, 0, 0, 0);
      // Crystal system oscillator without, then with, fast wake-up.
      halt(orfw_pkg::OSC_FAST_CRYSTAL, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0,
           orfw_pkg::PM_SLEEP_SUB, 1'b0, 1'b1, 1'b0, 1023, 1024, 0, 0);
      halt(orfw_pkg::OSC_FAST_CRYSTAL, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1,
           orfw_pkg::PM_SLEEP_SUB, 1'b0, 1'b1, 1'b1, 1023, 1024, 0, 0);
      halt(orfw_pkg::OSC_FAST_CRYSTAL, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1,
           orfw_pkg::PM_DOZE_OFF, 1'b0, 1'b1, 1'b1, 1023, 1024, 0, 0);
      // Deep sleep with a slow crystal: fast wake-up is requested but must not happen.
      halt(orfw_pkg::OSC_FAST_CRYSTAL, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1,
           orfw_pkg::PM_DEEP, 1'b0, 1'b0, 1'b0, 1023, 1024, 1023, 1024);
      // Slow RC as system oscillator: the wake waits on the low-speed flag only.
      halt(orfw_pkg::OSC_SLOW_INTERNAL_RC, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1,
           orfw_pkg::PM_DEEP, 1'b0, 1'b0, 1'b0, 15, 16, 1, 2);
      test_done();
   end
endmodule
